/* lpw_pkg.sv */
package lpw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VA_LO = 8'h08;
  localparam logic [7:0] OFS_VA_HI = 8'h0c;
  localparam logic [7:0] OFS_ROOT_LO = 8'h10;
  localparam logic [7:0] OFS_ROOT_HI = 8'h14;
  localparam logic [7:0] OFS_PA_LO = 8'h18;
  localparam logic [7:0] OFS_PA_HI = 8'h1c;
  localparam logic [7:0] OFS_QUERY_FN = 8'h20;
  localparam logic [7:0] OFS_QUERY_A = 8'h24;
  localparam logic [7:0] OFS_QUERY_B = 8'h28;
  localparam logic [7:0] OFS_QUERY_D = 8'h2c;
  localparam logic [7:0] OFS_INT_STATUS = 8'h30;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h34;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h38;
  localparam logic [7:0] OFS_ATTR = 8'h3c;
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STACK_BIT = 1;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_FAULT_BIT = 1;
  localparam int ENT_PRESENT_BIT = 0;
  localparam int ENT_PAGE_SIZE_BIT = 7;
  localparam int ENT_TOP_ZERO_BIT = 8;
  localparam int ENT_NO_EXEC_BIT = 63;
  localparam int FQ_1G_SUPPORT_BIT = 26;
  // Reset values
  localparam logic [31:0] RST_INT_ENABLE = 32'h0000_0000;
  localparam logic [63:0] RST_WORD64 = 64'h0000_0000_0000_0000;
  // Feature-query functions and bus response codes
  localparam logic [31:0] FQ_EXT_FEATURES = 32'h8000_0001;
  localparam logic [31:0] FQ_TLB_1G = 32'h8000_0019;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    F_NONE = 3'b000,
    F_PAGE = 3'b001,
    F_PROT = 3'b010,
    F_STACK = 3'b011,
    F_RSVD = 3'b100,
    F_SMALL = 3'b101
  } lpw_fault_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TOP = 2'b01,
    ST_SECOND = 2'b10,
    ST_THIRD = 2'b11
  } lpw_state_e;

  typedef struct packed {
    logic valid;
    logic [51:0] addr;
  } lpw_mem_req_s;

  typedef struct packed {
    logic valid;
    logic [63:0] data;
  } lpw_mem_rsp_s;
endpackage

/* lpw_walker.sv */
// Contract
// - 1G split in four fields, two indices
// - bits 63:48 must sign-extend bit 47
// - 47:39 top index, 38:30 second index
// - 1G offset is VA bits 29:0
// - third-level page-size set ends walk, 2M
// - no leaf entry read for 2M
// - second-level page-size set ends walk, 1G
// - 1G reads only top and second entries
// - upper levels decode as 4K path
// - top entry: base 51:12, no-exec, zero 8:7
// - 2M entry: base 51:21, zero 20:13, flags
// - 1G support in bit 26 of 8000_0001h
// - 8000_0019h returns L1 and L2 counts
// - 2M: 29:21 third index, 20:0 offset
// - not-present entry faults, never updated
// - non-canonical gives protection or stack fault
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module lpw_walker
  import lpw_pkg::*;
#(
  parameter bit SUPPORT_1G = 1'b1,
  parameter logic [31:0] L1_TLB_1G = 32'h0000_0020,
  parameter logic [31:0] L2_TLB_1G = 32'h0000_0400
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output lpw_mem_req_s memReq,
  input wire lpw_mem_rsp_s memRsp,
  output logic irq
);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus side state
  logic awHeld, wHeld, bValid, rValid;
  logic [7:0] awAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [63:0] va, root;
  logic stackRef;
  logic [31:0] queryFn, intEnable, intStatus;
  logic next_awHeld, next_wHeld, next_bValid, next_rValid;
  logic [7:0] next_awAddr;
  logic [31:0] next_wData, next_rData;
  logic [3:0] next_wStrb;
  logic [1:0] next_bResp, next_rResp;
  logic [63:0] next_va, next_root;
  logic next_stackRef;
  logic [31:0] next_queryFn, next_intEnable, next_intStatus;
  // Walker state
  lpw_state_e state, next_state;
  lpw_fault_e fault, next_fault;
  logic [51:0] memAddr, next_memAddr, pa, next_pa;
  logic [63:0] entry, next_entry;
  logic noExecAny, next_noExecAny, is1g, next_is1g;
  logic resultValid, next_resultValid;
  logic evDone, evFault;
  logic doWrite, startPulse, canonical;
  logic [31:0] queryA, queryB, queryD, statusWord;

  assign doWrite = awHeld && wHeld && !bValid;
  assign startPulse = doWrite && awAddr == OFS_CTRL && wStrb[0]
                      && wData[CTRL_START_BIT];
  assign canonical = va[63:48] == {16{va[47]}};

  always_comb begin
    queryA = 32'h0000_0000;
    queryB = 32'h0000_0000;
    queryD = 32'h0000_0000;
    if (queryFn == FQ_EXT_FEATURES) begin
      queryD[FQ_1G_SUPPORT_BIT] = SUPPORT_1G;
    end else if (queryFn == FQ_TLB_1G) begin
      queryA = L1_TLB_1G;
      queryB = L2_TLB_1G;
    end
  end

  assign statusWord = {23'h000000, is1g, 1'b0, fault, 2'h0,
                       resultValid, state != ST_IDLE};

  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    next_va = va;
    next_root = root;
    next_stackRef = stackRef;
    next_queryFn = queryFn;
    next_intEnable = intEnable;
    next_intStatus = intStatus;
    if (s_axi_awvalid && !awHeld) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = RESP_OKAY;
      case ({awAddr[7:2], 2'b00})
        OFS_CTRL: begin
          if (wStrb[0]) begin
            next_stackRef = wData[CTRL_STACK_BIT];
          end
        end
        OFS_VA_LO: next_va[31:0] = mergeStrb(va[31:0], wData, wStrb);
        OFS_VA_HI: next_va[63:32] = mergeStrb(va[63:32], wData, wStrb);
        OFS_ROOT_LO: next_root[31:0] = mergeStrb(root[31:0], wData, wStrb);
        OFS_ROOT_HI: begin
          next_root[63:32] = mergeStrb(root[63:32], wData, wStrb);
        end
        OFS_QUERY_FN: next_queryFn = mergeStrb(queryFn, wData, wStrb);
        OFS_INT_ENABLE: begin
          next_intEnable = mergeStrb(intEnable, wData, wStrb);
        end
        OFS_INT_CLEAR: begin
          next_intStatus = intStatus & ~mergeStrb(32'h0, wData, wStrb);
        end
        OFS_STATUS, OFS_PA_LO, OFS_PA_HI, OFS_QUERY_A, OFS_QUERY_B,
        OFS_QUERY_D, OFS_INT_STATUS, OFS_ATTR: begin
          next_bResp = RESP_OKAY;
        end
        default: next_bResp = RESP_SLVERR;
      endcase
    end
    // A walk event in the clearing cycle still lands
    next_intStatus[INT_DONE_BIT] = next_intStatus[INT_DONE_BIT] | evDone;
    next_intStatus[INT_FAULT_BIT] = next_intStatus[INT_FAULT_BIT] | evFault;
    if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    if (s_axi_arvalid && !rValid) begin
      next_rValid = 1'b1;
      next_rResp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_CTRL: next_rData = {30'h0, stackRef, 1'b0};
        OFS_STATUS: next_rData = statusWord;
        OFS_VA_LO: next_rData = va[31:0];
        OFS_VA_HI: next_rData = va[63:32];
        OFS_ROOT_LO: next_rData = root[31:0];
        OFS_ROOT_HI: next_rData = root[63:32];
        OFS_PA_LO: next_rData = pa[31:0];
        OFS_PA_HI: next_rData = {12'h000, pa[51:32]};
        OFS_QUERY_FN: next_rData = queryFn;
        OFS_QUERY_A: next_rData = queryA;
        OFS_QUERY_B: next_rData = queryB;
        OFS_QUERY_D: next_rData = queryD;
        OFS_INT_STATUS: next_rData = intStatus;
        OFS_INT_ENABLE: next_rData = intEnable;
        OFS_INT_CLEAR: next_rData = 32'h0000_0000;
        OFS_ATTR: next_rData = {noExecAny, 18'h00000, entry[12:0]};
        default: begin
          next_rData = 32'h0000_0000;
          next_rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= RESP_OKAY;
      rValid <= 1'b0;
      rData <= 32'h0000_0000;
      rResp <= RESP_OKAY;
      va <= RST_WORD64;
      root <= RST_WORD64;
      stackRef <= 1'b0;
      queryFn <= 32'h0000_0000;
      intEnable <= RST_INT_ENABLE;
      intStatus <= 32'h0000_0000;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
      va <= next_va;
      root <= next_root;
      stackRef <= next_stackRef;
      queryFn <= next_queryFn;
      intEnable <= next_intEnable;
      intStatus <= next_intStatus;
    end
  end

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;
  assign irq = |(intStatus & intEnable);

  // Walk: one entry read in flight; entries are only read, never written
  always_comb begin
    next_state = state;
    next_fault = fault;
    next_memAddr = memAddr;
    next_pa = pa;
    next_entry = entry;
    next_noExecAny = noExecAny;
    next_is1g = is1g;
    next_resultValid = resultValid;
    evDone = 1'b0;
    evFault = 1'b0;
    case (state)
      ST_IDLE: begin
        if (startPulse) begin
          next_resultValid = 1'b0;
          next_noExecAny = 1'b0;
          next_is1g = 1'b0;
          if (!canonical) begin
            // The stack flag rides on this very write; the register lags
            next_fault = wData[CTRL_STACK_BIT] ? F_STACK : F_PROT;
            evFault = 1'b1;
          end else begin
            next_fault = F_NONE;
            next_state = ST_TOP;
            next_memAddr = {root[51:12], va[47:39], 3'b000};
          end
        end
      end
      ST_TOP: begin
        if (memRsp.valid) begin
          next_entry = memRsp.data;
          if (!memRsp.data[ENT_PRESENT_BIT]) begin
            next_fault = F_PAGE;
            next_state = ST_IDLE;
            evFault = 1'b1;
          end else if (|memRsp.data[ENT_TOP_ZERO_BIT:ENT_PAGE_SIZE_BIT]) begin
            next_fault = F_RSVD;
            next_state = ST_IDLE;
            evFault = 1'b1;
          end else begin
            next_noExecAny = memRsp.data[ENT_NO_EXEC_BIT];
            next_state = ST_SECOND;
            next_memAddr = {memRsp.data[51:12], va[38:30], 3'b000};
          end
        end
      end
      ST_SECOND: begin
        if (memRsp.valid) begin
          next_entry = memRsp.data;
          if (!memRsp.data[ENT_PRESENT_BIT]) begin
            next_fault = F_PAGE;
            next_state = ST_IDLE;
            evFault = 1'b1;
          end else if (memRsp.data[ENT_PAGE_SIZE_BIT]) begin
            // 1G leaf: walk ends after two reads
            next_noExecAny = noExecAny | memRsp.data[ENT_NO_EXEC_BIT];
            next_pa = {memRsp.data[51:30], va[29:0]};
            next_is1g = 1'b1;
            next_resultValid = 1'b1;
            next_state = ST_IDLE;
            evDone = 1'b1;
          end else begin
            next_noExecAny = noExecAny | memRsp.data[ENT_NO_EXEC_BIT];
            next_state = ST_THIRD;
            next_memAddr = {memRsp.data[51:12], va[29:21], 3'b000};
          end
        end
      end
      ST_THIRD: begin
        if (memRsp.valid) begin
          next_entry = memRsp.data;
          next_state = ST_IDLE;
          if (!memRsp.data[ENT_PRESENT_BIT]) begin
            next_fault = F_PAGE;
            evFault = 1'b1;
          end else if (!memRsp.data[ENT_PAGE_SIZE_BIT]) begin
            // 4K tables are not walked by this block
            next_fault = F_SMALL;
            evFault = 1'b1;
          end else if (|memRsp.data[20:13]) begin
            next_fault = F_RSVD;
            evFault = 1'b1;
          end else begin
            next_noExecAny = noExecAny | memRsp.data[ENT_NO_EXEC_BIT];
            next_pa = {memRsp.data[51:21], va[20:0]};
            next_resultValid = 1'b1;
            evDone = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      fault <= F_NONE;
      memAddr <= 52'h0;
      pa <= 52'h0;
      entry <= RST_WORD64;
      noExecAny <= 1'b0;
      is1g <= 1'b0;
      resultValid <= 1'b0;
    end else begin
      state <= next_state;
      fault <= next_fault;
      memAddr <= next_memAddr;
      pa <= next_pa;
      entry <= next_entry;
      noExecAny <= next_noExecAny;
      is1g <= next_is1g;
      resultValid <= next_resultValid;
    end
  end

  assign memReq.valid = state != ST_IDLE;
  assign memReq.addr = memAddr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_secondLeaf;
    state == ST_SECOND && memRsp.valid && memRsp.data[0] && memRsp.data[7];
  endsequence
  sequence s_thirdLeaf;
    state == ST_THIRD && memRsp.valid && memRsp.data[0] && memRsp.data[7]
      && memRsp.data[20:13] == 8'h00;
  endsequence

  property p_canon;
    state == ST_IDLE && startPulse && !canonical |=>
      state == ST_IDLE && (fault == F_PROT || fault == F_STACK)
      && !memReq.valid;
  endproperty
  a_canon: assert property (p_canon) else $error("non-canonical walked");
  property p_topAddr;
    state == ST_IDLE && startPulse && canonical |=> state == ST_TOP
      && memReq.addr == {$past(root[51:12]), $past(va[47:39]), 3'b000};
  endproperty
  a_topAddr: assert property (p_topAddr) else $error("top index wrong");
  property p_secondAddr;
    state == ST_TOP && memRsp.valid && memRsp.data[0]
      && memRsp.data[8:7] == 2'b00 |=> state == ST_SECOND
      && memReq.addr == {$past(memRsp.data[51:12]), va[38:30], 3'b000};
  endproperty
  a_secondAddr: assert property (p_secondAddr) else $error("second addr");
  property p_thirdAddr;
    state == ST_SECOND && memRsp.valid && memRsp.data[0] && !memRsp.data[7]
      |=> state == ST_THIRD
      && memReq.addr == {$past(memRsp.data[51:12]), va[29:21], 3'b000};
  endproperty
  a_thirdAddr: assert property (p_thirdAddr) else $error("third addr");
  property p_giga;
    s_secondLeaf |=> !memReq.valid && is1g && resultValid
      && pa == {$past(memRsp.data[51:30]), va[29:0]};
  endproperty
  a_giga: assert property (p_giga) else $error("1G result wrong");
  property p_two;
    s_thirdLeaf |=> !memReq.valid && !is1g && resultValid
      && pa == {$past(memRsp.data[51:21]), va[20:0]};
  endproperty
  a_two: assert property (p_two) else $error("2M result wrong");
  property p_absent;
    state != ST_IDLE && memRsp.valid && !memRsp.data[0] |=>
      state == ST_IDLE && fault == F_PAGE && !resultValid;
  endproperty
  a_absent: assert property (p_absent) else $error("no page fault");
  property p_topMbz;
    state == ST_TOP && memRsp.valid && memRsp.data[0]
      && memRsp.data[8:7] != 2'b00 |=> fault == F_RSVD && state == ST_IDLE;
  endproperty
  a_topMbz: assert property (p_topMbz) else $error("top zero field missed");
  property p_query;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_QUERY_D
      && queryFn == FQ_EXT_FEATURES
      |=> s_axi_rdata[FQ_1G_SUPPORT_BIT] == SUPPORT_1G;
  endproperty
  a_query: assert property (p_query) else $error("1G flag wrong");
  property p_irq;
    evFault && intEnable[INT_FAULT_BIT] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("fault irq lost");

endmodule

/* lpw_mem_model.sv */
`timescale 1ns/1ps
module lpw_mem_model
  import lpw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire lpw_mem_req_s memReq,
  input wire logic [3:0] memDelay,
  output lpw_mem_rsp_s memRsp
);
  logic [63:0] mem [logic [51:0]];
  logic [51:0] addrLog [$];
  logic [3:0] waitCnt;

  // Unloaded entries read as zero, which is a not-present entry
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      memRsp <= '0;
      waitCnt <= 4'h0;
    end else if (memReq.valid && !memRsp.valid && waitCnt >= memDelay) begin
      memRsp.valid <= 1'b1;
      memRsp.data <= mem.exists(memReq.addr) ? mem[memReq.addr] : 64'h0;
      addrLog.push_back(memReq.addr);
      waitCnt <= 4'h0;
    end else begin
      // Scrambled outside the pulse so a stale entry is never reused
      memRsp.valid <= 1'b0;
      memRsp.data <= ~memRsp.data;
      waitCnt <= (memReq.valid && !memRsp.valid) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import lpw_pkg::*;
  localparam logic [31:0] L1N = 32'h0000_0020;
  localparam logic [31:0] L2N = 32'h0000_0400;
  localparam logic [51:0] ROOT = 52'h0_0000_0001_0000;
  typedef struct {
    logic [63:0] va, top, sec, thr;
    logic stk;
    lpw_fault_e fault;
    int reads;
  } lpw_row_s;

  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  lpw_mem_req_s memReq;
  lpw_mem_rsp_s memRsp;
  logic irq;
  logic [3:0] memDelay = 4'h0;
  logic [1:0] rsp;
  logic [51:0] expA [3];
  int mismatches = 0;
  int checks_done = 0;

  // The last row's top entry mixes in ignored and software bits that must not disturb its walk
  lpw_row_s rows [12] = '{
    '{64'h000012345678_9abc, 64'h2001, 64'h3001, 64'h40600081, 0, F_NONE, 3},
    '{64'hffff8123456789ab, 64'h2001, 64'h80000000c0000083, 64'h0, 0,
      F_NONE, 2},
    '{64'h0001000000000000, 64'h2001, 64'h3001, 64'h40600081, 0, F_PROT, 0},
    '{64'hfffe800000000000, 64'h2001, 64'h3001, 64'h40600081, 1, F_STACK, 0},
    '{64'h200000, 64'h2000, 64'h3001, 64'h40600081, 0, F_PAGE, 1},
    '{64'h200000, 64'h2001, 64'h3000, 64'h40600081, 0, F_PAGE, 2},
    '{64'h200000, 64'h2001, 64'h3001, 64'h40600080, 0, F_PAGE, 3},
    '{64'h200000, 64'h2101, 64'h3001, 64'h40600081, 0, F_RSVD, 1},
    '{64'h200000, 64'h2081, 64'h3001, 64'h40600081, 0, F_RSVD, 1},
    '{64'h200000, 64'h2001, 64'h3001, 64'h40602081, 0, F_RSVD, 3},
    '{64'h200000, 64'h2001, 64'h3001, 64'h40600001, 0, F_SMALL, 3},
    '{64'h00007fffffffffff, 64'h7ff0000000002e41, 64'h3001,
      64'h80000000406011ff, 0, F_NONE, 3}
  };

  always #4 ref_clk = ~ref_clk;

  lpw_walker #(.SUPPORT_1G(1'b1), .L1_TLB_1G(L1N), .L2_TLB_1G(L2N)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .memReq(memReq), .memRsp(memRsp),
    .irq(irq)
  );

  lpw_mem_model u_mem (
    .ref_clk(ref_clk), .reset_n(reset_n), .memReq(memReq),
    .memDelay(memDelay), .memRsp(memRsp)
  );

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        r = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
    if (!got) chk("write answer", got, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
    if (!got) chk("read answer", got, 1'b1);
  endtask

  task automatic start_walk(input lpw_row_s w);
    logic [31:0] d;
    wr(OFS_INT_CLEAR, 32'h3, rsp);
    rd(OFS_INT_STATUS, d, rsp);
    chk("int clear", d[1:0], 2'b00);
    chk("irq clear", irq, 1'b0);
    expA[0] = {ROOT[51:12], w.va[47:39], 3'b000};
    expA[1] = {w.top[51:12], w.va[38:30], 3'b000};
    expA[2] = {w.sec[51:12], w.va[29:21], 3'b000};
    u_mem.mem.delete();
    u_mem.addrLog.delete();
    u_mem.mem[expA[0]] = w.top;
    u_mem.mem[expA[1]] = w.sec;
    u_mem.mem[expA[2]] = w.thr;
    wr(OFS_ROOT_LO, ROOT[31:0], rsp);
    wr(OFS_ROOT_HI, {12'h0, ROOT[51:32]}, rsp);
    wr(OFS_VA_LO, w.va[31:0], rsp);
    wr(OFS_VA_HI, w.va[63:32], rsp);
    wr(OFS_CTRL, {30'h0, w.stk, 1'b1}, rsp);
  endtask

  task automatic finish_walk(input lpw_row_s w, input logic expIrq);
    int n;
    logic [31:0] st, lo, hi;
    logic [63:0] fin;
    logic [51:0] pa;
    n = 0;
    st = 32'h1;
    fin = (w.reads == 2) ? w.sec : w.thr;
    pa = (w.reads == 2) ? {w.sec[51:30], w.va[29:0]}
                        : {w.thr[51:21], w.va[20:0]};
    while (st[0] !== 1'b0 && n < 50) begin
      rd(OFS_STATUS, st, rsp);
      n++;
    end
    chk("walk ends", st[0], 1'b0);
    chk("irq", irq, expIrq);
    chk("fault", st[6:4], w.fault);
    chk("reads", u_mem.addrLog.size(), w.reads);
    for (int k = 0; k < w.reads && k < u_mem.addrLog.size(); k++)
      chk("entry addr", u_mem.addrLog[k], expA[k]);
    rd(OFS_INT_STATUS, lo, rsp);
    chk("fault event", lo[INT_FAULT_BIT], w.fault != F_NONE);
    chk("done event", lo[INT_DONE_BIT], w.fault == F_NONE);
    if (w.fault == F_NONE) begin
      rd(OFS_PA_LO, lo, rsp);
      rd(OFS_PA_HI, hi, rsp);
      chk("is1g", st[8], w.reads == 2);
      chk("phys addr", {hi[19:0], lo}, pa);
      rd(OFS_ATTR, lo, rsp);
      fin[63] = w.top[63] | w.sec[63] | fin[63];
      chk("attr", lo, {fin[63], 18'h0, fin[12:0]});
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFS_INT_ENABLE, d, r);
    chk("enable reset", d, RST_INT_ENABLE);
    rd(OFS_PA_LO, d, r);
    chk("pa reset", d, RST_WORD64[31:0]);
    chk("irq reset", irq, 1'b0);
    $display("reset test done");
    wr(OFS_INT_ENABLE, 32'h3, r);
    for (int i = 0; i < 12; i++) begin
      memDelay <= (i % 2) ? 4'h3 : 4'h0;
      start_walk(rows[i]);
      finish_walk(rows[i], 1'b1);
      $display("walk %0d done", i);
    end
    wr(OFS_QUERY_FN, FQ_EXT_FEATURES, r);
    rd(OFS_QUERY_D, d, r);
    chk("1g support", d[FQ_1G_SUPPORT_BIT], 1'b1);
    wr(OFS_QUERY_FN, FQ_TLB_1G, r);
    rd(OFS_QUERY_A, d, r);
    chk("l1 count", d, L1N);
    rd(OFS_QUERY_B, d, r);
    chk("l2 count", d, L2N);
    s_axi_wstrb <= 4'h3;
    wr(OFS_QUERY_FN, 32'hffff_ffff, r);
    s_axi_wstrb <= 4'hf;
    rd(OFS_QUERY_FN, d, r);
    chk("byte lanes", d, {FQ_TLB_1G[31:16], 16'hffff});
    $display("feature query test done");
    wr(8'h40, 32'hffff_ffff, r);
    chk("unmapped write", r, RESP_SLVERR);
    rd(8'h40, d, r);
    chk("unmapped read", {r, d}, {RESP_SLVERR, 32'h0});
    wr(OFS_STATUS, 32'hffff_ffff, r);
    chk("ro write", r, RESP_OKAY);
    rd(OFS_INT_CLEAR, d, r);
    chk("clear reads zero", d, 32'h0);
    $display("register test done");
    wr(OFS_INT_ENABLE, 32'h0, r);
    start_walk(rows[0]);
    finish_walk(rows[0], 1'b0);
    wr(OFS_INT_ENABLE, 32'h3, r);
    chk("irq unmasked", irq, 1'b1);
    $display("mask test done");
    // Reset lands while the walker waits on a slow entry read
    memDelay <= 4'h8;
    start_walk(rows[0]);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("req in reset", memReq.valid, 1'b0);
    chk("irq in reset", irq, 1'b0);
    reset_n <= 1'b1;
    rd(OFS_STATUS, d, r);
    chk("status after reset", d, 32'h0);
    memDelay <= 4'h1;
    wr(OFS_INT_ENABLE, 32'h3, r);
    start_walk(rows[1]);
    finish_walk(rows[1], 1'b1);
    $display("mid-walk reset test done");
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    wrap_up;
  end
endmodule
